// ===== bench/apms_link_props.sv
// link checker: timing relations on the select, clock and data wires
`timescale 1ns/1ps
module apms_link_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic convSelN,
  input wire logic serialClk,
  input wire logic serialResultOut,
  input wire logic serialResultOe,
  input wire logic dataLine
);
  import apms_pkg::*;
  logic [4:0] fallCnt;  // link clock falls since select fall

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // count link clock falls inside a frame, kept after select rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fallCnt <= 5'h00;
    end else if ($fell(convSelN)) begin
      fallCnt <= 5'h00;
    end else if (!convSelN && $fell(serialClk)) begin
      fallCnt <= fallCnt + 5'h01;
    end
  end

  // ****************************************
  // wire relations
  // ****************************************
  AST_SEL_FALL_DRIVES: assert property (
    $fell(convSelN) |-> ##[1:8] serialResultOe)
    else $error("data line not driven after select fall");
  AST_SEL_FALL_ZERO: assert property (
    $fell(convSelN) |-> ##[1:8] !dataLine)
    else $error("data line not low after select fall");
  AST_FIRST_ZERO: assert property (
    $rose(serialResultOe) |-> !serialResultOut)
    else $error("first bit of frame is not zero");
  AST_LEAD_ZEROS: assert property (
    serialResultOe && !convSelN && fallCnt < 5'h04 |-> !serialResultOut)
    else $error("leading bit is not zero");
  AST_OE_END_FRAME: assert property (
    $rose(convSelN) |-> ##[1:8] !serialResultOe)
    else $error("data line still driven after select rise");
  AST_OE_AFTER_16: assert property (
    fallCnt == FRAME_FALLS && $changed(fallCnt) |-> ##[1:8] !serialResultOe)
    else $error("data line still driven after last fall");
  AST_QUIET: assert property (
    $rose(convSelN) |=> convSelN [*8])
    else $error("select lowered inside quiet time");
  AST_FRAME_FALLS: assert property (
    $rose(convSelN) |-> fallCnt == PD_BURST_FALLS || fallCnt == FRAME_FALLS)
    else $error("frame ended with wrong clock count");
  AST_SCLK_IDLE: assert property (
    convSelN |-> serialClk)
    else $error("link clock low outside a frame");
endmodule // apms_link_props

// ===== bench/tb.sv
// bench: host and converter ends joined, plus a converter end driven directly
`timescale 1ns/1ps
module tb;
  import apms_pkg::*;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                clkEn = 1'b1;
  logic                cmdValid = 1'b0;
  apms_cmd_t           cmd = APMS_CMD_CONVERT;
  logic                cmdReady, resultValid, analogOn, trackMode, powerDown;
  logic                fullyPowered, convValid;
  logic                analogOnB, trackModeB, powerDownB, fullyPoweredB, convValidB;
  logic [SAMPLE_W-1:0] result;
  logic [SAMPLE_W-1:0] sample = 12'h000;
  logic [SAMPLE_W-1:0] sampleB = 12'h000;
  logic                convSeenB = 1'b0;
  logic                pdB = 1'b1;
  logic                gotRes, gotConv;
  int                  bad_count = 0;
  int                  comparisons = 0;
  int                  seed = 10;
  int                  cycles = 0;
  int                  fpAt = 0;
  int                  r;
  int                  cornerN [12] = '{1, 16, 1, 12, 2, 9, 10, 16, 16, 8, 5, 1};

  apms_if link ();
  apms_if linkB ();

  apms_device #(.START_POWER_DOWN(1'b0)) u_apms_device (.clk(clk), .rst(rst), .clkEn(clkEn),
    .link(link), .analogInput(sample), .analogOn(analogOn), .trackMode(trackMode),
    .powerDown(powerDown), .fullyPowered(fullyPowered), .convValid(convValid));
  apms_host u_apms_host (.clk(clk), .rst(rst), .clkEn(clkEn), .link(link),
    .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady), .result(result),
    .resultValid(resultValid));
  apms_device #(.START_POWER_DOWN(1'b1)) u_apms_device_b (.clk(clk), .rst(rst), .clkEn(clkEn),
    .link(linkB), .analogInput(sampleB), .analogOn(analogOnB), .trackMode(trackModeB),
    .powerDown(powerDownB), .fullyPowered(fullyPoweredB), .convValid(convValidB));
  apms_link_props u_apms_link_props (.clk(clk), .rst(rst), .convSelN(link.convSelN),
    .serialClk(link.serialClk), .serialResultOut(link.serialResultOut),
    .serialResultOe(link.serialResultOe), .dataLine(link.dataLine));

  // clock
  always #2 clk = ~clk;

  // cycle count, power-up moment, pulse capture, hang limit
  always @(posedge clk) begin
    if (!rst) cycles++;
    if (fullyPowered === 1'b1 && fpAt == 0) fpAt = cycles;
    if (convValidB === 1'b1) convSeenB = 1'b1;
    if (cycles > 20000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // mode after a frame of n falls
  function automatic logic expPd(input logic pd, input int n);
    if (n < 2) return pd;
    return (n < 10);
  endfunction

  // one host command, waiting for the host to become ready again
  task automatic hostCmd(input apms_cmd_t c, output logic res, output logic conv);
    int n;
    res = 1'b0;
    conv = 1'b0;
    n = 0;
    @(negedge clk);
    cmdValid = 1'b1;
    cmd = c;
    while (cmdReady !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmdValid = 1'b0;
    do begin
      @(negedge clk);
      n++;
      res |= (resultValid === 1'b1);
      conv |= (convValid === 1'b1);
    end while (cmdReady !== 1'b1 && n < 1000);
    check(n < 1000, "command done");
  endtask

  // one frame of n link clock falls on the directly driven end
  task automatic runB(input int n);
    logic [WORD_W-1:0] word;
    int                v;
    v = $random(seed);
    word = '0;
    sampleB = v[SAMPLE_W-1:0];
    convSeenB = 1'b0;
    linkB.convSelN = 1'b0;
    repeat (8) @(negedge clk);
    if (pdB) check(analogOnB === 1'b1 && trackModeB === 1'b0, "wake start");
    for (int i = 1; i <= n; i++) begin
      word = {word[WORD_W-2:0], linkB.dataLine};
      linkB.serialClk = 1'b0;
      repeat (8) @(negedge clk);
      if (pdB && i == 1) check(trackModeB === 1'b1, "track after edge");
      linkB.serialClk = 1'b1;
      repeat (8) @(negedge clk);
    end
    linkB.convSelN = 1'b1;
    repeat (24) @(negedge clk);
    if (n >= 10 && n < 16 && pdB) repeat (300) @(negedge clk);  // early end of wake
    check(linkB.serialResultOe === 1'b0, "data released");
    check(convSeenB === (n == 16 && !pdB), "valid pulse");
    if (n == 16 && !pdB) check(word === {4'h0, sampleB}, "frame word");
    pdB = expPd(pdB, n);
    check(powerDownB === pdB, "mode bit");
    check(analogOnB === !pdB && trackModeB === !pdB, "analog and track");
    if (!pdB) check(fullyPoweredB === 1'b1, "powered");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    linkB.convSelN = 1'b1;
    linkB.serialClk = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check(trackMode === 1'b1 && powerDown === 1'b0, "start normal");
    check(trackModeB === 1'b1 && powerDownB === 1'b1, "start down");
    check(analogOnB === 1'b0, "start analog off");
    // frames right after power-on, corners then random counts
    for (int i = 0; i < 12; i++) runB(cornerN[i]);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      runB(1 + ($unsigned(r) % 16));
    end
    check(fpAt >= POWER_UP_CYCLES - 2 && fpAt <= POWER_UP_CYCLES + 2, "power-up");
    // host end against converter end
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      sample = (i == 0) ? 12'hFFF : r[SAMPLE_W-1:0];
      hostCmd(APMS_CMD_CONVERT, gotRes, gotConv);
      check(gotRes === 1'b1 && result === sample, "host result");
      check(gotConv === 1'b1 && powerDown === 1'b0, "normal conversion");
    end
    hostCmd(APMS_CMD_POWER_DOWN, gotRes, gotConv);
    check(powerDown === 1'b1 && analogOn === 1'b0, "host power-down");
    check(trackMode === 1'b0, "held while down");
    check(gotRes === 1'b0, "no result from burst");
    hostCmd(APMS_CMD_WAKE, gotRes, gotConv);
    check(powerDown === 1'b0 && fullyPowered === 1'b1, "host wake");
    check(gotConv === 1'b0 && analogOn === 1'b1, "wake frame not valid");
    check(trackMode === 1'b1, "tracking after wake");
    hostCmd(APMS_CMD_CONVERT, gotRes, gotConv);
    check(gotRes === 1'b1 && result === sample, "result after wake");
    check(gotConv === 1'b1, "valid after wake");
    // clock enable low freezes the directly driven end
    clkEn = 1'b0;
    linkB.convSelN = 1'b0;
    repeat (16) @(negedge clk);
    check(powerDownB === pdB && linkB.serialResultOe === 1'b0, "frozen");
    linkB.convSelN = 1'b1;
    repeat (4) @(negedge clk);
    clkEn = 1'b1;
    repeat (8) @(negedge clk);
    check(linkB.serialResultOe === 1'b0, "no frame after freeze");
    conclude();
  end
endmodule // tb

// ===== rtl/apms_device.sv
// converter end: power-mode sequencing and serial result output
`timescale 1ns/1ps
module apms_device #(
  parameter bit START_POWER_DOWN = 1'b0
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           clkEn,
  apms_if.device                              link,
  input  wire logic [apms_pkg::SAMPLE_W-1:0]  analogInput,
  output logic                                analogOn,
  output logic                                trackMode,
  output logic                                powerDown,
  output logic                                fullyPowered,
  output logic                                convValid
);
  import apms_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_FRAME = 1'b1
  } apms_dev_state_t;

  // ****************************************
  // declarations
  // ****************************************
  apms_dev_state_t         state;
  logic                    selLevel;
  logic                    selRise;
  logic                    selFall;
  logic                    clkLevel;
  logic                    clkRise;
  logic                    clkFall;
  logic [FALL_CNT_W-1:0]   fallCount;
  logic [WORD_W-1:0]       shiftWord;
  logic [8:0]              puTimer;
  logic                    wakeCycle;
  logic                    frameGood;
  logic                    trackArmed;
  logic                    inFrame;
  logic                    frameFall;
  logic                    lastFall;
  logic                    frameEnd;
  logic                    next_powerDown;

  // refuse a power-up count that the 9-bit timer cannot hold
  if (POWER_UP_CYCLES < 1 || POWER_UP_CYCLES > 511) begin : gPuCheck
    $error("power-up count does not fit its timer");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  apms_sync_edge #(.RESET_LEVEL(1'b1)) selSync (
    .clk   (clk),
    .rst   (rst),
    .clkEn (clkEn),
    .pinIn (link.convSelN),
    .level (selLevel),
    .rise  (selRise),
    .fall  (selFall)
  );

  apms_sync_edge #(.RESET_LEVEL(1'b1)) clkSync (
    .clk   (clk),
    .rst   (rst),
    .clkEn (clkEn),
    .pinIn (link.serialClk),
    .level (clkLevel),
    .rise  (clkRise),
    .fall  (clkFall)
  );

  // ****************************************
  // frame decode
  // ****************************************
  // frame events
  assign inFrame   = (state == ST_FRAME);
  assign frameFall = inFrame & clkFall & ~selLevel;
  assign lastFall  = frameFall & (fallCount == FRAME_FALLS - 5'h01);
  assign frameEnd  = inFrame & selRise;

  // mode after a select rise, from the falls counted
  always_comb begin
    next_powerDown = powerDown;
    if (frameEnd) begin
      if (fallCount >= WAKE_MIN_FALLS) begin
        next_powerDown = 1'b0;
      end else if (fallCount >= PD_MIN_FALLS) begin
        next_powerDown = 1'b1;
      end
    end
  end

  // frame state follows select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else if (clkEn) begin
      if (selFall) begin
        state <= ST_FRAME;
      end else if (selRise) begin
        state <= ST_IDLE;
      end
    end
  end

  // falls since the select fall, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fallCount <= '0;
    end else if (clkEn) begin
      if (selFall) begin
        fallCount <= '0;
      end else if (frameFall && fallCount != FRAME_FALLS) begin
        fallCount <= fallCount + 5'h01;
      end
    end
  end

  // ****************************************
  // power mode
  // ****************************************
  // single mode bit updated on select rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerDown <= START_POWER_DOWN;
    end else if (clkEn) begin
      powerDown <= next_powerDown;
    end
  end

  // frame kind recorded at select fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wakeCycle <= 1'b0;
      frameGood <= 1'b0;
    end else if (clkEn && selFall) begin
      wakeCycle <= powerDown;
      frameGood <= fullyPowered & ~powerDown;
    end
  end

  // analog supply enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      analogOn <= ~START_POWER_DOWN;
    end else if (clkEn) begin
      if (selFall) begin
        analogOn <= 1'b1;
      end else if (frameEnd) begin
        analogOn <= ~next_powerDown;
      end
    end
  end

  // power-up timer while analog is on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      puTimer      <= '0;
      fullyPowered <= 1'b0;
    end else if (clkEn) begin
      if (!analogOn || (frameEnd && next_powerDown)) begin
        puTimer      <= '0;
        fullyPowered <= 1'b0;
      end else if (!fullyPowered) begin
        puTimer <= puTimer + 9'h001;
        if (puTimer == 9'(POWER_UP_CYCLES - 1)) begin
          fullyPowered <= 1'b1;
        end else if (lastFall && wakeCycle) begin
          fullyPowered <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // track and hold
  // ****************************************
  // hold at sample, track after the bit cycle or wake edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trackMode  <= 1'b1;
      trackArmed <= 1'b0;
    end else if (clkEn) begin
      if (selFall) begin
        trackMode  <= 1'b0;
        trackArmed <= 1'b0;
      end else if (frameEnd) begin
        trackMode <= ~next_powerDown;
      end else if (inFrame && wakeCycle && (clkRise || clkFall)) begin
        trackMode <= 1'b1;
      end else if (frameFall && fallCount == TRACK_AFTER_FALLS - 5'h01) begin
        trackArmed <= 1'b1;
      end else if (inFrame && trackArmed && clkRise) begin
        trackMode <= 1'b1;
      end
    end
  end

  // ****************************************
  // serial result
  // ****************************************
  // sample at select fall, shift out on each fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shiftWord            <= '0;
      link.serialResultOut <= 1'b0;
    end else if (clkEn) begin
      if (selFall) begin
        shiftWord            <= {{LEAD_ZEROS{1'b0}}, analogInput};
        link.serialResultOut <= 1'b0;
      end else if (frameFall) begin
        shiftWord            <= {shiftWord[WORD_W-2:0], 1'b0};
        link.serialResultOut <= shiftWord[WORD_W-2];
      end
    end
  end

  // data line driven from select fall to the last fall or select rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.serialResultOe <= 1'b0;
    end else if (clkEn) begin
      if (selFall) begin
        link.serialResultOe <= 1'b1;
      end else if (frameEnd || lastFall) begin
        link.serialResultOe <= 1'b0;
      end
    end
  end

  // pulse when a valid conversion completes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      convValid <= 1'b0;
    end else if (clkEn) begin
      convValid <= lastFall & frameGood & ~wakeCycle;
    end
  end
endmodule // apms_device

// ===== rtl/apms_host.sv
// host end: frames select and serial clock, reads the result
`timescale 1ns/1ps
module apms_host #(
  parameter int HALF_CYCLES  = apms_pkg::SCLK_HALF_CYCLES,
  parameter int QUIET_COUNT  = apms_pkg::QUIET_CYCLES
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           clkEn,
  apms_if.host                                link,
  input  wire logic                           cmdValid,
  input  wire apms_pkg::apms_cmd_t            cmd,
  output logic                                cmdReady,
  output logic [apms_pkg::SAMPLE_W-1:0]       result,
  output logic                                resultValid
);
  import apms_pkg::*;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_RUN   = 2'b01,
    HS_QUIET = 2'b10
  } apms_host_state_t;

  apms_host_state_t      state;
  apms_cmd_t             curCmd;
  logic [7:0]            timer;
  logic [FALL_CNT_W-1:0] falls;
  logic [FALL_CNT_W-1:0] target;
  logic [WORD_W-1:0]     rxWord;
  logic                  dataLevel;
  logic                  halfDone;

  // refuse counts that the 8-bit timer or the round trip cannot serve
  if (HALF_CYCLES < 8 || HALF_CYCLES > 255 ||
      QUIET_COUNT < 1 || QUIET_COUNT > 255) begin : gParamCheck
    $error("host timing parameters out of range");
  end

  // ****************************************
  // data line synchroniser
  // ****************************************
  apms_sync_edge #(.RESET_LEVEL(1'b1)) dataSync (
    .clk   (clk),
    .rst   (rst),
    .clkEn (clkEn),
    .pinIn (link.dataLine),
    .level (dataLevel),
    .rise  (),
    .fall  ()
  );

  assign halfDone = (timer == 8'(HALF_CYCLES - 1));

  // ****************************************
  // frame sequencer
  // ****************************************
  // idle ready at reset so a dummy frame can go at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state          <= HS_IDLE;
      curCmd         <= APMS_CMD_CONVERT;
      target         <= FRAME_FALLS;
      timer          <= '0;
      falls          <= '0;
      cmdReady       <= 1'b1;
      link.convSelN  <= 1'b1;
      link.serialClk <= 1'b1;
    end else if (clkEn) begin
      unique case (state)
        HS_IDLE: begin
          if (cmdValid) begin
            curCmd        <= cmd;
            target        <= (cmd == APMS_CMD_POWER_DOWN) ? PD_BURST_FALLS
                                                          : FRAME_FALLS;
            timer         <= '0;
            falls         <= '0;
            cmdReady      <= 1'b0;
            link.convSelN <= 1'b0;
            state         <= HS_RUN;
          end
        end
        HS_RUN: begin
          timer <= halfDone ? 8'h00 : timer + 8'h01;
          if (halfDone) begin
            if (link.serialClk) begin
              link.serialClk <= 1'b0;
              falls          <= falls + 5'h01;
            end else if (falls == target) begin
              link.convSelN <= 1'b1;
              state         <= HS_QUIET;
            end else begin
              link.serialClk <= 1'b1;
            end
          end
          if (halfDone && !link.serialClk && falls == target) begin
            link.serialClk <= 1'b1;
          end
        end
        HS_QUIET: begin
          timer <= timer + 8'h01;
          if (timer == 8'(QUIET_COUNT - 1)) begin
            cmdReady <= 1'b1;
            state    <= HS_IDLE;
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // result capture
  // ****************************************
  // one bit per fall made, word reported at end of quiet time for conversions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxWord      <= '0;
      result      <= '0;
      resultValid <= 1'b0;
    end else if (clkEn) begin
      resultValid <= 1'b0;
      if (state == HS_RUN && halfDone && link.serialClk) begin
        rxWord <= {rxWord[WORD_W-2:0], dataLevel};
      end
      if (state == HS_QUIET && timer == 8'(QUIET_COUNT - 1) && curCmd == APMS_CMD_CONVERT) begin
        result      <= rxWord[SAMPLE_W-1:0];
        resultValid <= 1'b1;
      end
    end
  end
endmodule // apms_host

// ===== rtl/apms_sync_edge.sv
// two-flop synchroniser with edge detection
`timescale 1ns/1ps
module apms_sync_edge #(
  parameter bit RESET_LEVEL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clkEn,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic prev;

  // two stages, then one more for edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta  <= RESET_LEVEL;
      level <= RESET_LEVEL;
      prev  <= RESET_LEVEL;
    end else if (clkEn) begin
      meta  <= pinIn;
      level <= meta;
      prev  <= level;
    end
  end

  // edges of the synchronised level
  assign rise = clkEn & level & ~prev;
  assign fall = clkEn & ~level & prev;
endmodule // apms_sync_edge

// ===== shared/apms_if.sv
// link between converter end and host end
`timescale 1ns/1ps
interface apms_if;
  logic convSelN;         // conversion select, active low
  logic serialClk;        // serial clock made by the host
  logic serialResultOut;  // data driven by the converter
  logic serialResultOe;   // converter drives the data line
  logic dataLine;         // resolved data line, pulled high when released

  // resolve the shared data wire
  assign dataLine = serialResultOe ? serialResultOut : 1'b1;

  modport device (input convSelN, input serialClk, output serialResultOut,
                  output serialResultOe);
  modport host (output convSelN, output serialClk, input dataLine);
endinterface // apms_if

// ===== shared/apms_pkg.sv
// shared constants and types of the power-mode sequencer link
package apms_pkg;
  // ****************************************
  // frame geometry
  // ****************************************
  localparam int         SAMPLE_W          = 12;
  localparam int         WORD_W            = 16;
  localparam int         LEAD_ZEROS        = WORD_W - SAMPLE_W;
  localparam int         FALL_CNT_W        = 5;
  localparam logic [4:0] PD_MIN_FALLS      = 5'h02;  // first count that can power down
  localparam logic [4:0] WAKE_MIN_FALLS    = 5'h0A;  // count that keeps or wakes power
  localparam logic [4:0] TRACK_AFTER_FALLS = 5'h0D;  // track resumes on next rise
  localparam logic [4:0] FRAME_FALLS       = 5'h10;  // full conversion and read-out
  localparam logic [4:0] PD_BURST_FALLS    = 5'h08;  // host burst that powers down

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int POWER_UP_NS      = 1000;  // longest power-up time
  localparam int POWER_UP_CYCLES  = (POWER_UP_NS * 1000) / CLK_PERIOD_PS;
  localparam int QUIET_NS         = 50;    // least quiet time before a new frame
  localparam int QUIET_CYCLES     = (QUIET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCLK_PERIOD_NS   = 64;
  localparam int SCLK_HALF_CYCLES = (SCLK_PERIOD_NS * 1000) / (2 * CLK_PERIOD_PS);

  // ****************************************
  // host commands
  // ****************************************
  typedef enum logic [1:0] {
    APMS_CMD_CONVERT    = 2'b00,
    APMS_CMD_POWER_DOWN = 2'b01,
    APMS_CMD_WAKE       = 2'b10
  } apms_cmd_t;
endpackage
